// >>> design/irq_xfer_channels.sv
`timescale 1ns/1ps
`default_nettype none
module irq_xfer_channels
    import irq_xfer_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output var  logic [31:0] reg_rdata_o,
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_chan_ptr_i,
    input  wire logic [7:0]  req_mode_i,
    output var  logic        req_ack_o,
    output var  logic [19:0] mem_addr_o,
    output var  logic        mem_re_o,
    output var  logic        mem_we_o,
    output var  logic [7:0]  mem_wdata_o,
    input  wire logic [7:0]  mem_rdata_i,
    output var  logic [7:0]  sfr_addr_o,
    output var  logic        sfr_re_o,
    output var  logic        sfr_we_o,
    output var  logic        sfr_wide_o,
    output var  logic [15:0] sfr_wdata_o,
    input  wire logic [15:0] sfr_rdata_i,
    output var  logic        busy_o,
    output var  logic        done_o,
    output var  logic        end_irq_o,
    output var  logic        vect_irq_o
);

    // ****************************************
    // State
    // ****************************************
    state_e      state;
    state_e      ret_st;
    logic [7:0]  chan_ptr;
    logic [7:0]  mode;
    logic [3:0]  idx;
    logic [3:0]  last;
    logic [3:0]  iss_tag;
    logic [3:0]  mrd_tag;
    logic        mrd_q;
    logic        srd_q;
    logic [7:0]  rbuf [16];
    logic [15:0] sbuf;
    logic [1:0]  ctrl;
    logic        zero_flag;
    logic        vect_flag;
    logic [15:0] done_cnt;

    function automatic logic [3:0] desc_len_f(input logic [7:0] m);
        case (m[MODE_TYPE_LSB +: 2])
            TYPE_A:  desc_len_f = LEN_A;
            TYPE_B:  desc_len_f = LEN_B;
            default: desc_len_f = m[MODE_RING_BIT] ? LEN_CR : LEN_C;
        endcase
    endfunction

    // ****************************************
    // Decode
    // ****************************************
    wire         is_a     = mode[MODE_TYPE_LSB +: 2] == TYPE_A;
    wire         is_b     = mode[MODE_TYPE_LSB +: 2] == TYPE_B;
    wire         is_c     = !is_a && !is_b;
    wire         dir      = mode[MODE_DIR_BIT];
    wire         word     = mode[MODE_WORD_BIT];
    wire         tstep    = mode[MODE_TSTEP_BIT];
    wire         add_en   = mode[MODE_ADD_BIT];
    wire         ring     = mode[MODE_RING_BIT];
    wire         evs      = mode[MODE_EVS_BIT];
    wire [3:0]   len_now  = desc_len_f(mode);
    wire [11:0]  win_hi   = ctrl[CTRL_MAP_BIT] ? HIGH_WIN_HI : LOW_WIN_HI;

    // ****************************************
    // Descriptor fields
    // ****************************************
    wire [15:0]  cnt16    = is_a ? {8'h00, rbuf[D_CNT_HI]} : {rbuf[D_CNT_HI], rbuf[D_CNT_LO]};
    wire [7:0]   peripheral_reg_pointer     = is_a ? rbuf[D_PERIPHERAL_REG_POINTER_A] : rbuf[D_PERIPHERAL_REG_POINTER];
    wire [7:0]   pattern_reg_pointer    = rbuf[D_PATTERN_REG_POINTER];
    // Bits 20 to 23 are left to software and ignored here
    wire [19:0]  ptr_b    = {rbuf[D_PTR][3:0], rbuf[D_PTR+1], rbuf[D_PTR+2]};
    wire [19:0]  pattern_buffer_pointer      = {rbuf[D_MPD][3:0], rbuf[D_MPD+1], rbuf[D_MPD+2]};
    wire [7:0]   a_off    = word ? {rbuf[D_CNT_HI][6:0], 1'b0} : rbuf[D_CNT_HI];
    wire [7:0]   abuf     = chan_ptr - a_off - 8'h01;
    wire [19:0]  dbase    = is_a ? {win_hi, abuf} : ptr_b;

    // ****************************************
    // Memory address and data for the current tag
    // ****************************************
    // Tags below 12 are descriptor bytes counted down from the count byte
    wire         tag_desc = idx < TAG_DLO;
    wire [7:0]   desc_lo  = chan_ptr - {4'h0, idx};
    wire [19:0]  iss_addr = tag_desc ? {win_hi, desc_lo}
                          : (idx == TAG_PAT) ? pattern_buffer_pointer
                          : dbase + {19'h0, idx[0]};
    wire [7:0]   iss_wdat = tag_desc ? rbuf[idx] : (idx[0] ? sbuf[15:8] : sbuf[7:0]);

    // ****************************************
    // Transfer data
    // ****************************************
    wire [15:0]  tval     = word ? {rbuf[TAG_DHI], rbuf[TAG_DLO]} : {8'h00, rbuf[TAG_DLO]};
    wire [15:0]  sum      = sbuf + tval;
    wire [15:0]  cwr_data = add_en ? sum : tval;

    // ****************************************
    // Descriptor update
    // ****************************************
    wire [15:0]  cnt_n    = cnt16 - 16'h0001;
    wire [19:0]  tsz      = word ? 20'h00002 : 20'h00001;
    wire [19:0]  ptr_b_n  = ptr_b + tsz;
    wire [7:0]   rc_n     = rbuf[D_RC] - 8'h01;
    wire         wrap     = is_c && ring && (rc_n == 8'h00);
    wire [19:0]  rl_m1    = {12'h000, rbuf[D_RL] - 8'h01};
    wire [19:0]  toff     = word ? {rl_m1[18:0], 1'b0} : rl_m1;
    // A wrap undoes the steps made since the first pattern
    wire [19:0]  mpd_n    = wrap ? (dir ? pattern_buffer_pointer - rl_m1 : pattern_buffer_pointer + rl_m1)
                          : (dir ? pattern_buffer_pointer + 20'h00001 : pattern_buffer_pointer - 20'h00001);
    wire [19:0]  mpt_n    = !tstep ? ptr_b
                          : wrap ? (dir ? ptr_b - toff : ptr_b + toff)
                          : (dir ? ptr_b + tsz : ptr_b - tsz);
    wire [19:0]  ptr_n    = is_b ? ptr_b_n : mpt_n;

    // ****************************************
    // Register bus decode
    // ****************************************
    wire         ctrl_hit = reg_addr_i == CTRL_OFS;
    wire         stat_hit = reg_addr_i == STAT_OFS;
    wire         cnt_hit  = reg_addr_i == DONE_CNT_OFS;
    wire [31:0]  stat_val = {29'h0, vect_flag, zero_flag, busy_o};
    wire [31:0]  rd_mux   = ctrl_hit ? {30'h0, ctrl}
                          : stat_hit ? stat_val
                          : cnt_hit ? {16'h0, done_cnt}
                          : 32'h0;
    wire         set_zero = (state == ST_DONE) && (cnt16 == 16'h0000);
    wire         set_vect = (state == ST_PLAN) && (cnt16 == 16'h0000);
    wire         clr_zero = reg_we_i && stat_hit && reg_wdata_i[STAT_ZERO];
    wire         clr_vect = reg_we_i && stat_hit && reg_wdata_i[STAT_VECT];

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl        <= CTRL_RST;
            reg_rdata_o <= 32'h0;
            zero_flag   <= 1'b0;
            vect_flag   <= 1'b0;
        end else begin
            if (reg_we_i && ctrl_hit) begin
                ctrl <= reg_wdata_i[1:0];
            end
            reg_rdata_o <= reg_re_i ? rd_mux : 32'h0;
            // Set wins over a clear in the same cycle
            zero_flag   <= set_zero || (zero_flag && !clr_zero);
            vect_flag   <= set_vect || (vect_flag && !clr_vect);
        end
    end

    // ****************************************
    // Read return capture and descriptor store
    // ****************************************
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mrd_q   <= 1'b0;
            mrd_tag <= 4'h0;
            srd_q   <= 1'b0;
            sbuf    <= 16'h0000;
        end else begin
            mrd_q   <= mem_re_o;
            mrd_tag <= iss_tag;
            srd_q   <= sfr_re_o;
            if (srd_q) begin
                sbuf <= sfr_rdata_i;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 16; i++) begin
                rbuf[i] <= 8'h00;
            end
        end else if (state == ST_UPD) begin
            if (is_a) begin
                rbuf[D_CNT_HI] <= cnt_n[7:0];
            end else begin
                rbuf[D_CNT_HI] <= cnt_n[15:8];
                rbuf[D_CNT_LO] <= cnt_n[7:0];
            end
            if (!is_a) begin
                rbuf[D_PTR]   <= {rbuf[D_PTR][7:4], ptr_n[19:16]};
                rbuf[D_PTR+1] <= ptr_n[15:8];
                rbuf[D_PTR+2] <= ptr_n[7:0];
            end
            if (is_c) begin
                rbuf[D_MPD]   <= {rbuf[D_MPD][7:4], mpd_n[19:16]};
                rbuf[D_MPD+1] <= mpd_n[15:8];
                rbuf[D_MPD+2] <= mpd_n[7:0];
            end
            if (is_c && ring) begin
                rbuf[D_RC] <= wrap ? rbuf[D_RL] : rc_n;
            end
        end else if (mrd_q) begin
            rbuf[mrd_tag] <= mem_rdata_i;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state       <= ST_IDLE;
            ret_st      <= ST_IDLE;
            chan_ptr    <= 8'h00;
            mode        <= 8'h00;
            idx         <= 4'h0;
            last        <= 4'h0;
            iss_tag     <= 4'h0;
            req_ack_o   <= 1'b0;
            mem_addr_o  <= 20'h00000;
            mem_re_o    <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_wdata_o <= 8'h00;
            sfr_addr_o  <= 8'h00;
            sfr_re_o    <= 1'b0;
            sfr_we_o    <= 1'b0;
            sfr_wide_o  <= 1'b0;
            sfr_wdata_o <= 16'h0000;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            end_irq_o   <= 1'b0;
            vect_irq_o  <= 1'b0;
            done_cnt    <= 16'h0000;
        end else begin
            req_ack_o  <= 1'b0;
            mem_re_o   <= 1'b0;
            mem_we_o   <= 1'b0;
            sfr_re_o   <= 1'b0;
            sfr_we_o   <= 1'b0;
            done_o     <= 1'b0;
            end_irq_o  <= 1'b0;
            vect_irq_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid_i && ctrl[CTRL_EN_BIT]) begin
                        chan_ptr  <= req_chan_ptr_i;
                        mode      <= req_mode_i;
                        idx       <= 4'h0;
                        last      <= desc_len_f(req_mode_i) - 4'h1;
                        ret_st    <= ST_PLAN;
                        req_ack_o <= 1'b1;
                        busy_o    <= 1'b1;
                        state     <= ST_RD;
                    end
                end
                ST_RD: begin
                    mem_re_o   <= 1'b1;
                    mem_addr_o <= iss_addr;
                    iss_tag    <= idx;
                    idx        <= idx + 4'h1;
                    if (idx == last) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Leave on the edge that captures the last return
                    if ((mrd_q && !mem_re_o) || (srd_q && !sfr_re_o)) begin
                        state <= ret_st;
                    end
                end
                ST_PLAN: begin
                    if (cnt16 == 16'h0000) begin
                        // Count already spent: hand over as a vectored request
                        vect_irq_o <= 1'b1;
                        busy_o     <= 1'b0;
                        state      <= ST_IDLE;
                    end else if (is_c) begin
                        idx    <= TAG_DLO;
                        last   <= TAG_PAT;
                        ret_st <= ST_XFER;
                        state  <= ST_RD;
                    end else if (dir) begin
                        idx    <= TAG_DLO;
                        last   <= word ? TAG_DHI : TAG_DLO;
                        ret_st <= ST_XFER;
                        state  <= ST_RD;
                    end else begin
                        idx    <= TAG_DLO;
                        last   <= word ? TAG_DHI : TAG_DLO;
                        ret_st <= ST_MWR;
                        state  <= ST_SRD;
                    end
                end
                ST_XFER: begin
                    if (is_c) begin
                        ret_st <= ST_CWR;
                        state  <= add_en ? ST_SRD : ST_CWR;
                    end else begin
                        sfr_we_o    <= 1'b1;
                        sfr_addr_o  <= peripheral_reg_pointer;
                        sfr_wide_o  <= word;
                        sfr_wdata_o <= tval;
                        state       <= ST_UPD;
                    end
                end
                ST_SRD: begin
                    sfr_re_o   <= 1'b1;
                    sfr_addr_o <= peripheral_reg_pointer;
                    sfr_wide_o <= word;
                    state      <= ST_WAIT;
                end
                ST_CWR: begin
                    sfr_we_o    <= 1'b1;
                    sfr_addr_o  <= peripheral_reg_pointer;
                    sfr_wide_o  <= word;
                    sfr_wdata_o <= cwr_data;
                    state       <= ST_PWR;
                end
                ST_PWR: begin
                    sfr_we_o    <= 1'b1;
                    sfr_addr_o  <= pattern_reg_pointer;
                    sfr_wide_o  <= 1'b0;
                    sfr_wdata_o <= {8'h00, rbuf[TAG_PAT]};
                    state       <= ST_UPD;
                end
                ST_MWR: begin
                    mem_we_o    <= 1'b1;
                    mem_addr_o  <= iss_addr;
                    mem_wdata_o <= iss_wdat;
                    idx         <= idx + 4'h1;
                    if (idx == last) begin
                        state <= ST_UPD;
                    end
                end
                ST_UPD: begin
                    idx   <= 4'h0;
                    last  <= len_now - 4'h1;
                    state <= ST_WB;
                end
                ST_WB: begin
                    mem_we_o    <= 1'b1;
                    mem_addr_o  <= iss_addr;
                    mem_wdata_o <= iss_wdat;
                    idx         <= idx + 4'h1;
                    if (idx == last) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    done_o    <= 1'b1;
                    end_irq_o <= (cnt16 == 16'h0000) && !evs;
                    done_cnt  <= done_cnt + 16'h0001;
                    busy_o    <= 1'b0;
                    state     <= ST_IDLE;
                end
                default: begin
                    busy_o <= 1'b0;
                    state  <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> common/irq_xfer_pkg.sv
package irq_xfer_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  CTRL_OFS     = 8'h00;
    localparam logic [7:0]  STAT_OFS     = 8'h04;
    localparam logic [7:0]  DONE_CNT_OFS = 8'h08;
    localparam int          CTRL_MAP_BIT = 0;
    localparam int          CTRL_EN_BIT  = 1;
    localparam logic [1:0]  CTRL_RST     = 2'h0;
    localparam int          STAT_BUSY    = 0;
    localparam int          STAT_ZERO    = 1;
    localparam int          STAT_VECT    = 2;

    // ****************************************
    // Descriptor window, upper address bits
    // ****************************************
    localparam logic [11:0] LOW_WIN_HI   = 12'h0fe;
    localparam logic [11:0] HIGH_WIN_HI  = 12'hffe;

    // ****************************************
    // Mode byte fields and channel types
    // ****************************************
    localparam int          MODE_TYPE_LSB = 0;
    localparam int          MODE_DIR_BIT  = 2;
    localparam int          MODE_WORD_BIT = 3;
    localparam int          MODE_TSTEP_BIT = 4;
    localparam int          MODE_ADD_BIT  = 5;
    localparam int          MODE_RING_BIT = 6;
    localparam int          MODE_EVS_BIT  = 7;
    localparam logic [1:0]  TYPE_A        = 2'h0;
    localparam logic [1:0]  TYPE_B        = 2'h1;
    localparam logic [1:0]  TYPE_C        = 2'h2;

    // ****************************************
    // Descriptor layout, bytes below the pointer
    // ****************************************
    localparam logic [3:0]  LEN_A    = 4'h2;
    localparam logic [3:0]  LEN_B    = 4'h6;
    localparam logic [3:0]  LEN_C    = 4'ha;
    localparam logic [3:0]  LEN_CR   = 4'hc;
    localparam int          D_CNT_HI = 0;
    localparam int          D_CNT_LO = 1;
    localparam int          D_PERIPHERAL_REG_POINTER_A = 1;
    localparam int          D_PERIPHERAL_REG_POINTER   = 2;
    localparam int          D_PTR    = 3;
    localparam int          D_PATTERN_REG_POINTER  = 6;
    localparam int          D_MPD    = 7;
    localparam int          D_RL     = 10;
    localparam int          D_RC     = 11;
    localparam logic [3:0]  TAG_DLO  = 4'hc;
    localparam logic [3:0]  TAG_DHI  = 4'hd;
    localparam logic [3:0]  TAG_PAT  = 4'he;

    typedef enum logic [3:0] {
        ST_IDLE, ST_RD, ST_WAIT, ST_PLAN, ST_XFER, ST_SRD, ST_CWR,
        ST_PWR, ST_MWR, ST_UPD, ST_WB, ST_DONE
    } state_e;

endpackage

// >>> sim/xfer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module xfer_checker (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        reg_re_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        req_valid_i,
    input wire logic        req_ack_o,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic        end_irq_o,
    input wire logic        vect_irq_o,
    input wire logic        mem_re_o,
    input wire logic        mem_we_o,
    input wire logic        sfr_we_o
);
    // ****************************************
    // Port relations
    // ****************************************
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_fin;
        done_o || vect_irq_o;
    endsequence
    a_ack_one_pulse: assert property (req_ack_o |=> !req_ack_o) else $error("ack longer than one cycle");
    a_busy_on_ack: assert property (req_ack_o |-> busy_o) else $error("ack without busy");
    a_ack_from_req: assert property (req_ack_o |-> $past(req_valid_i) && !$past(busy_o)) else $error("stray ack");
    a_end_with_done: assert property (end_irq_o |-> done_o) else $error("end request without done");
    a_vect_alone: assert property (vect_irq_o |-> !done_o && !end_irq_o) else $error("vectored with done");
    a_vect_no_write: assert property (vect_irq_o |-> !mem_we_o && !sfr_we_o) else $error("write on zero count");
    a_mem_excl: assert property (!(mem_re_o && mem_we_o)) else $error("memory read and write together");
    a_rdata_read: assert property (reg_rdata_o != 0 |-> $past(reg_re_i)) else $error("read data without read");
    // Long ring descriptors take the most cycles, hence the wide bound
    a_done_bounded: assert property (req_ack_o |-> ##[1:200] s_fin) else $error("transfer never finished");
endmodule
bind irq_xfer_channels xfer_checker chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .req_valid_i(req_valid_i), .req_ack_o(req_ack_o), .busy_o(busy_o), .done_o(done_o),
    .end_irq_o(end_irq_o), .vect_irq_o(vect_irq_o), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o), .sfr_we_o(sfr_we_o));
`default_nettype wire

// >>> sim/mem_sfr_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_sfr_model (
    input  wire logic        clock_i,
    input  wire logic [19:0] mem_addr_i,
    input  wire logic        mem_re_i,
    input  wire logic        mem_we_i,
    input  wire logic [7:0]  mem_wdata_i,
    output var  logic [7:0]  mem_rdata_o,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_re_i,
    input  wire logic        sfr_we_i,
    input  wire logic        sfr_wide_i,
    input  wire logic [15:0] sfr_wdata_i,
    output var  logic [15:0] sfr_rdata_o
);
    logic [7:0]  mem [int];
    logic [15:0] sfr [256];
    initial begin
        mem_rdata_o = 8'h00;
        sfr_rdata_o = 16'h0000;
    end
    // Stale data inverts each cycle so a late sample cannot match
    always @(posedge clock_i) begin
        mem_rdata_o <= mem_re_i ? mem[mem_addr_i] : ~mem_rdata_o;
        sfr_rdata_o <= sfr_re_i ? sfr[sfr_addr_i] : ~sfr_rdata_o;
        if (mem_we_i)
            mem[mem_addr_i] = mem_wdata_i;
        if (sfr_we_i && sfr_wide_i)
            sfr[sfr_addr_i] = sfr_wdata_i;
        if (sfr_we_i && !sfr_wide_i)
            sfr[sfr_addr_i][7:0] = sfr_wdata_i[7:0];
    end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top import irq_xfer_pkg::*; ;
    logic        clock_i, rst_n_i, reg_we_i, reg_re_i, req_valid_i, map;
    logic [7:0]  reg_addr_i, req_chan_ptr_i, req_mode_i, mem_rdata_i, mem_wdata_o, sfr_addr_o, p, s, v, m;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    logic [19:0] mem_addr_o, b, c;
    logic [15:0] sfr_rdata_i, sfr_wdata_o, w, x, t;
    logic        req_ack_o, mem_re_o, mem_we_o, sfr_re_o, sfr_we_o, sfr_wide_o, busy_o, done_o, end_irq_o, vect_irq_o;
    logic [2:0]  fin;
    int          bad_count = 0, cmp_count = 0, k, n;
    irq_xfer_channels dut_u (.clock_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
        .req_valid_i, .req_chan_ptr_i, .req_mode_i, .req_ack_o, .mem_addr_o, .mem_re_o, .mem_we_o, .mem_wdata_o,
        .mem_rdata_i, .sfr_addr_o, .sfr_re_o, .sfr_we_o, .sfr_wide_o, .sfr_wdata_o, .sfr_rdata_i, .busy_o, .done_o,
        .end_irq_o, .vect_irq_o);
    mem_sfr_model mdl_u (.clock_i, .mem_addr_i(mem_addr_o), .mem_re_i(mem_re_o), .mem_we_i(mem_we_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .sfr_addr_i(sfr_addr_o), .sfr_re_i(sfr_re_o),
        .sfr_we_i(sfr_we_o), .sfr_wide_i(sfr_wide_o), .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [19:0] d(input logic [7:0] q, input int i);
        return {map ? 12'hffe : 12'h0fe, q - 8'(i)};
    endfunction
    function automatic logic [23:0] get3(input int i);
        return {mdl_u.mem[d(p, i)], mdl_u.mem[d(p, i + 1)], mdl_u.mem[d(p, i + 2)]};
    endfunction
    task automatic put(input int i, input logic [7:0] e);
        mdl_u.mem[d(p, i)] = e;
    endtask
    task automatic put3(input int i, input logic [19:0] e);
        put(i, {4'h0, e[19:16]});
        put(i + 1, e[15:8]);
        put(i + 2, e[7:0]);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= e;
        @(posedge clock_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_re_i <= 1'b0;
        #1 `CHK("reg", e, reg_rdata_o)
    endtask
    // Valid is held until the ack is seen, as the handshake demands
    // Own loop counter, so the caller's count in n survives the call
    task automatic go(input logic [7:0] mode);
        int i;
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_chan_ptr_i <= p;
        req_mode_i <= mode;
        for (i = 0; i < 20 && req_ack_o !== 1'b1; i++)
            @(posedge clock_i) #1;
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        for (i = 0; i < 300 && done_o !== 1'b1 && vect_irq_o !== 1'b1; i++)
            @(posedge clock_i) #1;
        fin = {done_o, end_irq_o, vect_irq_o};
        `CHK("finished", 1'b1, done_o | vect_irq_o)
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
    initial begin
        {rst_n_i, reg_we_i, reg_re_i, req_valid_i, map, reg_addr_i, reg_wdata_i, req_chan_ptr_i, req_mode_i} = '0;
        k = $urandom(32'ha1f1);
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(CTRL_OFS, 0);
        rd(STAT_OFS, 0);
        wr(8'h0c, '1);
        rd(8'h0c, 0);
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        // Dropped before enable, else a stray request is taken
        req_valid_i <= 1'b0;
        #1 `CHK("ack_off", 1'b0, req_ack_o)
        `CHK("busy_off", 1'b0, busy_o)
        $display("test registers done");
        wr(CTRL_OFS, 32'h2);
        for (k = 0; k < 2; k++) begin
            p = 8'($urandom);
            s = 8'($urandom);
            v = 8'($urandom);
            n = k ? 1 : $urandom_range(2, 60);
            put(0, 8'(n));
            put(1, s);
            put(n + 1, v);
            m = 8'(n);
            go(8'h04);
            `CHK("a_sfr", v, mdl_u.sfr[s][7:0])
            `CHK("a_cnt", m - 8'h1, mdl_u.mem[d(p, 0)])
            `CHK("a_end", k == 1, fin[1])
        end
        map = 1'b1;
        wr(CTRL_OFS, 32'h3);
        p = 8'($urandom);
        s = 8'($urandom);
        w = 16'($urandom);
        n = $urandom_range(1, 60);
        put(0, 8'(n));
        put(1, s);
        mdl_u.sfr[s] = w;
        go(8'h08);
        `CHK("aw_lo", w[7:0], mdl_u.mem[d(p, 2 * n + 1)])
        `CHK("aw_hi", w[15:8], mdl_u.mem[d(p, 2 * n)])
        $display("test type a done");
        b = {4'h1, 16'($urandom)};
        v = 8'($urandom);
        put(0, 0);
        put(1, 1);
        put(2, s);
        put3(3, b);
        mdl_u.mem[b] = v;
        go(8'h85);
        `CHK("b_sfr", v, mdl_u.sfr[s][7:0])
        `CHK("b_cnt", 16'h0, {mdl_u.mem[d(p, 0)], mdl_u.mem[d(p, 1)]})
        `CHK("b_ptr", 24'(b + 1), get3(3))
        `CHK("b_end", 1'b0, fin[1])
        go(8'h85);
        `CHK("b_vect", 3'b001, fin)
        rd(STAT_OFS, 32'h6);
        wr(STAT_OFS, 32'h6);
        rd(STAT_OFS, 32'h0);
        $display("test type b done");
        for (k = 0; k < 2; k++) begin
            m = k ? 8'h12 : 8'h6e;
            b = {4'h2, 16'($urandom)};
            c = {4'h3, 16'($urandom)};
            w = 16'($urandom);
            x = 16'($urandom);
            put(0, 0);
            put(1, 5);
            put(2, s);
            put3(3, b);
            put(6, s ^ 8'h1);
            put3(7, c);
            put(10, 3);
            put(11, 1);
            mdl_u.mem[b] = x[7:0];
            mdl_u.mem[b + 1] = x[15:8];
            mdl_u.mem[c] = v;
            mdl_u.sfr[s] = w;
            go(m);
            t = m[5] ? w + x : x;
            `CHK("c_tim", m[3] ? t : {w[15:8], t[7:0]}, mdl_u.sfr[s])
            `CHK("c_pat", v, mdl_u.sfr[s ^ 8'h1][7:0])
            `CHK("c_pptr", 24'(k ? c - 1 : c - 2), get3(7))
            `CHK("c_tptr", 24'(k ? b - 1 : b), get3(3))
            `CHK("c_ring", 8'(k ? 1 : 3), mdl_u.mem[d(p, 11)])
            `CHK("c_cnt", 8'h4, mdl_u.mem[d(p, 1)])
        end
        $display("test type c done");
        // Two byte, one word, one type B and two type C runs complete
        rd(DONE_CNT_OFS, 32'h6);
        end_sim();
    end
endmodule
`default_nettype wire
